// ==== core/smi_defs.svh ====
/*
 Constants of the microstep indexer: register map, field positions,
 reset values and timing figures. Assumes a 100 MHz pclk.
*/
`ifndef SMI_DEFS_SVH
`define SMI_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SMI_CTRL_OFS 8'h00
`define SMI_STAT_OFS 8'h04
`define SMI_INT_OFS 8'h08
`define SMI_MASK_OFS 8'h0C
`define SMI_CTRL_RST 1'h0
`define SMI_CTRL_FAST_BIT 0
`define SMI_STAT_POS_LSB 0
`define SMI_STAT_SH_LSB 8
`define SMI_STAT_ST_LSB 12
`define SMI_STAT_UV_BIT 16
`define SMI_STAT_BR_BIT 17
`define SMI_INT_STEP_BIT 0
`define SMI_INT_UV_BIT 1
`define SMI_INT_RUN_BIT 2
`define SMI_INT_RST 3'h0
`define SMI_MASK_RST 3'h0
// ----------------------------------------
// Indexer and supply
// ----------------------------------------
`define SMI_HOME_POS 7'h10
`define SMI_FULL_OFS 7'h10
`define SMI_UV_FALL_MV 16'd2900
`define SMI_UV_RISE_MV 16'd3000
// ----------------------------------------
// Timing
// ----------------------------------------
`define SMI_CLK_NS 10
`define SMI_TOFF_LO_US 20
`define SMI_TOFF_Z_US 10
`define SMI_TOFF_HI_US 30
`define SMI_T_SLEEP_US 1000
`define SMI_T_WAKE_US 1000
`define SMI_T_ON_US 1000
`define SMI_CYC(us) ((us) * 1000 / `SMI_CLK_NS)
`endif

// ==== core/smi_pkg.sv ====
/*
 Types of the microstep indexer.
 Assumes smi_defs.svh for constants.
*/
package smi_pkg;
  // Resolved tri-level pin
  typedef enum logic [1:0] {
    TRI_LOW = 2'b00,
    TRI_OPEN = 2'b01,
    TRI_HIGH = 2'b10
  } smi_tri_t;
  // Sensed tri-level pin: above high, below low threshold
  typedef struct packed {
    logic hi;
    logic lo;
  } smi_tri_pin_t;
  // Power sequencing state
  typedef enum logic [1:0] {
    ST_LOCK = 2'b00,
    ST_WAKE = 2'b01,
    ST_RUN = 2'b10,
    ST_DOZE = 2'b11
  } smi_state_t;
  // Winding drive
  typedef struct packed {
    logic signed [7:0] cur_a;
    logic signed [7:0] cur_b;
  } smi_drive_t;
endpackage : smi_pkg

// ==== core/smi_indexer.sv ====
/*
 Microstep indexer with power sequencing, off-time chopping, decay choice,
 open-drain fault and an APB register slave.
 Assumes synchronous pins, tri-level pins sensed by two comparators, and a
 digitised motor supply in millivolts.
*/
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "smi_defs.svh"
module smi_indexer #(
  parameter int unsigned SLEEP_CYC = `SMI_CYC(`SMI_T_SLEEP_US),
  parameter int unsigned ON_CYC = `SMI_CYC(`SMI_T_ON_US),
  parameter int unsigned CW = 17
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step,
  input wire logic step_direction,
  input wire logic output_disable_n,
  input wire logic sleep_request_low,
  input wire logic auto_decay_enable,
  input wire smi_pkg::smi_tri_pin_t step_mode_sel0,
  input wire smi_pkg::smi_tri_pin_t step_mode_sel1,
  input wire smi_pkg::smi_tri_pin_t torque_scale_sel0,
  input wire smi_pkg::smi_tri_pin_t torque_scale_sel1,
  input wire smi_pkg::smi_tri_pin_t offtime_select,
  input wire logic [15:0] motor_supply,
  input wire logic [1:0] chop_trip,
  input wire logic fault_ext,
  output smi_pkg::smi_drive_t drive,
  output logic bridge_enable,
  output logic [1:0] chop_off,
  output logic [1:0] decay_fast,
  output logic sleep_active,
  output logic fault_indicator_n_o,
  output logic fault_indicator_n_oe,
  output logic irq
);
  // ----------------------------------------
  // Tri-level resolution
  // ----------------------------------------
  function automatic smi_pkg::smi_tri_t res(smi_pkg::smi_tri_pin_t p);
    if (p.lo) return smi_pkg::TRI_LOW;
    else if (p.hi) return smi_pkg::TRI_HIGH;
    else return smi_pkg::TRI_OPEN;
  endfunction : res

  wire smi_pkg::smi_tri_t m0 = res(step_mode_sel0);
  wire smi_pkg::smi_tri_t m1 = res(step_mode_sel1);
  wire smi_pkg::smi_tri_t t0 = res(torque_scale_sel0);
  wire smi_pkg::smi_tri_t t1 = res(torque_scale_sel1);
  wire smi_pkg::smi_tri_t tf = res(offtime_select);

  // ----------------------------------------
  // Step mode decode
  // ----------------------------------------
  // Shift gives step size 1 << sh; 5 is full step
  logic [2:0] sh;
  logic dual;
  always_comb begin
    sh = 3'd5;
    dual = 1'b0;
    unique case ({m1, m0})
      {smi_pkg::TRI_LOW, smi_pkg::TRI_LOW}: sh = 3'd5;
      {smi_pkg::TRI_LOW, smi_pkg::TRI_OPEN}: sh = 3'd4;
      {smi_pkg::TRI_LOW, smi_pkg::TRI_HIGH}: sh = 3'd3;
      {smi_pkg::TRI_OPEN, smi_pkg::TRI_LOW}: sh = 3'd2;
      {smi_pkg::TRI_OPEN, smi_pkg::TRI_OPEN}: begin
        sh = 3'd2;
        dual = 1'b1;
      end
      {smi_pkg::TRI_OPEN, smi_pkg::TRI_HIGH}: sh = 3'd1;
      {smi_pkg::TRI_HIGH, smi_pkg::TRI_LOW}: begin
        sh = 3'd1;
        dual = 1'b1;
      end
      {smi_pkg::TRI_HIGH, smi_pkg::TRI_OPEN}: sh = 3'd0;
      {smi_pkg::TRI_HIGH, smi_pkg::TRI_HIGH}: begin
        sh = 3'd0;
        dual = 1'b1;
      end
      default: sh = 3'd5;
    endcase
  end

  // ----------------------------------------
  // Supply lockout and power sequencing
  // ----------------------------------------
  smi_pkg::smi_state_t st_q, st_d;
  logic uvlo_q, uvlo_d;
  logic [CW-1:0] cnt_q, cnt_d;
  assign uvlo_d = uvlo_q ? (motor_supply <= `SMI_UV_RISE_MV)
                         : (motor_supply < `SMI_UV_FALL_MV);
  wire cnt_on_end = cnt_q == CW'(ON_CYC - 1);
  wire cnt_sl_end = cnt_q == CW'(SLEEP_CYC - 1);
  wire run_ev = st_q == smi_pkg::ST_WAKE && cnt_on_end
                && sleep_request_low;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CW'(1);
    unique case (st_q)
      smi_pkg::ST_LOCK: begin
        cnt_d = '0;
        if (sleep_request_low) st_d = smi_pkg::ST_WAKE;
      end
      smi_pkg::ST_WAKE: begin
        if (!sleep_request_low) st_d = smi_pkg::ST_LOCK;
        else if (cnt_on_end) st_d = smi_pkg::ST_RUN;
      end
      smi_pkg::ST_RUN: begin
        cnt_d = '0;
        if (!sleep_request_low) st_d = smi_pkg::ST_DOZE;
      end
      smi_pkg::ST_DOZE: begin
        if (cnt_sl_end) st_d = smi_pkg::ST_LOCK;
      end
    endcase
    if (uvlo_q) begin
      st_d = smi_pkg::ST_LOCK;
      cnt_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= smi_pkg::ST_LOCK;
      uvlo_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      uvlo_q <= uvlo_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Indexer
  // ----------------------------------------
  logic step_q;
  logic [6:0] pos_q, pos_d;
  wire rise = step && !step_q;
  wire fall = !step && step_q;
  wire run = st_q == smi_pkg::ST_RUN;
  wire adv = (rise || (fall && dual)) && (run || st_q == smi_pkg::ST_DOZE);
  wire [6:0] sz = 7'(7'h01 << sh);
  wire [6:0] msk = ~(sz - 7'h01);
  wire [6:0] ofs = (sh == 3'd5) ? `SMI_FULL_OFS : 7'h00;
  wire [6:0] rel = pos_q - ofs;
  wire [6:0] up = (rel & msk) + sz + ofs;
  wire [6:0] dn = (((rel & ~msk) == 7'h00) ? rel - sz : rel & msk) + ofs;

  assign pos_d = step_direction ? up : dn;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 1'b0;
      pos_q <= `SMI_HOME_POS;
    end else begin
      step_q <= step;
      if (st_q == smi_pkg::ST_LOCK) pos_q <= `SMI_HOME_POS;
      else if (adv) pos_q <= pos_d;
    end
  end

  // ----------------------------------------
  // Current table and torque scale
  // ----------------------------------------
  localparam logic [6:0] SINQ [33] = '{
    7'd0, 7'd5, 7'd10, 7'd15, 7'd20, 7'd24, 7'd29, 7'd34, 7'd38,
    7'd43, 7'd47, 7'd51, 7'd56, 7'd60, 7'd63, 7'd67, 7'd71, 7'd74,
    7'd77, 7'd80, 7'd83, 7'd86, 7'd88, 7'd90, 7'd92, 7'd94, 7'd96,
    7'd97, 7'd98, 7'd99, 7'd100, 7'd100, 7'd100};

  wire [3:0] tq = 4'd8 - 4'(2'(t1) * 3) - 4'(t0);

  function automatic logic signed [7:0] lvl(logic [6:0] p,
                                            logic [3:0] t);
    logic [5:0] k;
    logic [10:0] m;
    k = p[5] ? 6'd32 - 6'(p[4:0]) : 6'(p[4:0]);
    m = 11'(SINQ[k]) * 11'(t);
    return p[6] ? -$signed({1'b0, m[9:3]}) : $signed({1'b0, m[9:3]});
  endfunction : lvl

  wire signed [7:0] tgt_a = lvl(pos_q + 7'h20, tq);
  wire signed [7:0] tgt_b = lvl(pos_q, tq);
  wire [7:0] ma_n = tgt_a < 0 ? -tgt_a : tgt_a;
  wire [7:0] mb_n = tgt_b < 0 ? -tgt_b : tgt_b;
  wire [7:0] ma_q = drive.cur_a < 0 ? -drive.cur_a : drive.cur_a;
  wire [7:0] mb_q = drive.cur_b < 0 ? -drive.cur_b : drive.cur_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drive <= '0;
    else drive <= '{cur_a: tgt_a, cur_b: tgt_b};
  end

  assign bridge_enable = run && !output_disable_n && tq != 4'd0;
  assign sleep_active = st_q == smi_pkg::ST_LOCK;

  // ----------------------------------------
  // Off-time chopping and decay
  // ----------------------------------------
  logic [11:0] toff;
  always_comb begin
    unique case (tf)
      smi_pkg::TRI_LOW: toff = 12'(`SMI_CYC(`SMI_TOFF_LO_US));
      smi_pkg::TRI_OPEN: toff = 12'(`SMI_CYC(`SMI_TOFF_Z_US));
      smi_pkg::TRI_HIGH: toff = 12'(`SMI_CYC(`SMI_TOFF_HI_US));
      default: toff = 12'(`SMI_CYC(`SMI_TOFF_Z_US));
    endcase
  end

  logic ctrl_fast_q;
  logic [1:0] dec_q;
  wire [1:0] fall_mag = {mb_n < mb_q, ma_n < ma_q};
  wire [1:0] chg_mag = {mb_n != mb_q, ma_n != ma_q};
  logic [11:0] toff_cnt_q [2];

  for (genvar i = 0; i < 2; i++) begin : g_wind
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        toff_cnt_q[i] <= '0;
        dec_q[i] <= 1'b0;
      end else begin
        if (chop_off[i]) toff_cnt_q[i] <= toff_cnt_q[i] - 12'd1;
        else if (chop_trip[i] && bridge_enable) toff_cnt_q[i] <= toff;
        if (chg_mag[i]) dec_q[i] <= fall_mag[i];
      end
    end
    assign chop_off[i] = toff_cnt_q[i] != 12'd0;
    assign decay_fast[i] = auto_decay_enable ? dec_q[i] : ctrl_fast_q;
  end

  // ----------------------------------------
  // Fault pin
  // ----------------------------------------
  assign fault_indicator_n_o = 1'b0;
  assign fault_indicator_n_oe = !(uvlo_q || fault_ext);

  // ----------------------------------------
  // APB registers and interrupts
  // ----------------------------------------
  logic [2:0] int_q, mask_q;
  logic [31:0] rd_q;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == `SMI_CTRL_OFS;
  wire hit_stat = paddr == `SMI_STAT_OFS;
  wire hit_int = paddr == `SMI_INT_OFS;
  wire hit_mask = paddr == `SMI_MASK_OFS;
  wire hit = hit_ctrl || hit_stat || hit_int || hit_mask;
  wire [2:0] ev = {run_ev, uvlo_d && !uvlo_q, adv && run};
  wire [31:0] stat = 32'({bridge_enable, uvlo_q, 2'b00, st_q, 1'b0,
                         sh, 1'b0, pos_q});
  wire [31:0] rd_d = hit_ctrl ? 32'(ctrl_fast_q) :
                     hit_stat ? stat :
                     hit_int ? 32'(int_q) :
                     hit_mask ? 32'(mask_q) : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = rd_q;
  assign irq = |(int_q & mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_fast_q <= `SMI_CTRL_RST;
      int_q <= `SMI_INT_RST;
      mask_q <= `SMI_MASK_RST;
      rd_q <= '0;
    end else begin
      if (psel && !penable) rd_q <= rd_d;
      if (wr && hit_ctrl) ctrl_fast_q <= pwdata[`SMI_CTRL_FAST_BIT];
      if (wr && hit_mask) mask_q <= pwdata[2:0];
      int_q <= (int_q & ~((wr && hit_int) ? pwdata[2:0] : 3'h0)) | ev;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  home_when_locked_a: assert property (
    st_q == smi_pkg::ST_LOCK |=> pos_q == `SMI_HOME_POS)
    else $error("indexer not at home after lock");
  step_moves_a: assert property (
    run && rise && st_d == smi_pkg::ST_RUN |=> pos_q != $past(pos_q))
    else $error("step edge did not move indexer");
  single_edge_a: assert property (
    run && fall && !dual |=> $stable(pos_q))
    else $error("falling edge moved in single-edge mode");
  disable_bridge_a: assert property (
    output_disable_n |-> !bridge_enable)
    else $error("bridge enabled while disabled");
  fine_up_a: assert property (
    run && rise && sh == 3'd0 && step_direction
    && st_d == smi_pkg::ST_RUN |=> pos_q == $past(pos_q) + 7'h01)
    else $error("upward step size wrong");
  wake_bound_a: assert property (
    st_q == smi_pkg::ST_WAKE |-> cnt_q < CW'(ON_CYC))
    else $error("wake time exceeded");
  sleep_bound_a: assert property (
    st_q == smi_pkg::ST_DOZE |-> cnt_q < CW'(SLEEP_CYC))
    else $error("sleep entry time exceeded");
  uv_fall_a: assert property (
    motor_supply < `SMI_UV_FALL_MV |=> uvlo_q)
    else $error("lockout not entered");
  uv_hold_a: assert property (
    uvlo_q && motor_supply <= `SMI_UV_RISE_MV |=> uvlo_q)
    else $error("lockout left below release level");
  toff_len_a: assert property (
    !chop_off[0] && chop_trip[0] && bridge_enable
    |=> toff_cnt_q[0] == $past(toff))
    else $error("off time not loaded");
  zero_torque_a: assert property (
    tq == 4'd0 |-> !bridge_enable)
    else $error("bridge on at zero torque");

  step_up_c: cover property (run && rise && step_direction);
  dual_fall_c: cover property (run && fall && dual);
  wake_run_c: cover property (run_ev);
  doze_lock_c: cover property (
    st_q == smi_pkg::ST_DOZE ##1 st_q == smi_pkg::ST_LOCK);
endmodule : smi_indexer

// ==== sim/smi_step_ctrl.sv ====
/*
 Step and direction source that drives the indexer pins.
 Assumes one request pulse from the bench at a time.
*/
`timescale 1ns/1ps
module smi_step_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic dir_req,
  output logic done,
  output logic step,
  output logic step_direction
);
  logic [2:0] cnt_q;
  // --------------------------------
  // Direction settles, then one edge
  // --------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      step <= 1'b0;
      step_direction <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (req && cnt_q == 3'h0) begin
        step_direction <= dir_req;
        cnt_q <= 3'h4;
      end else if (cnt_q == 3'h2) begin
        step <= ~step;
        cnt_q <= 3'h1;
      end else if (cnt_q == 3'h1) begin
        done <= 1'b1;
        cnt_q <= 3'h0;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule : smi_step_ctrl

// ==== sim/stepper_microstep_indexer_bench.sv ====
/*
 Self-checking bench of the microstep indexer.
 Assumes the step source model and APB with zero wait states allowed.
*/
`timescale 1ns/1ps
`include "smi_defs.svh"
module stepper_microstep_indexer_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e, step, step_direction, req = 0, dir_req = 0;
  logic done, output_disable_n = 0, sleep_request_low = 0, fault_ext = 0;
  logic auto_decay_enable = 0, bridge_enable, sleep_active, fo, foe, irq;
  smi_pkg::smi_tri_pin_t m0 = 2'b01, m1 = 2'b01, t0 = 2'b01, t1 = 2'b01;
  smi_pkg::smi_tri_pin_t toff = 2'b01;
  logic [15:0] motor_supply = 16'h07D0;
  logic [1:0] chop_trip = 2'b00, chop_off, decay_fast;
  smi_pkg::smi_drive_t drive;
  logic [1:0] pins [3] = '{2'b01, 2'b00, 2'b10};
  int shf [9] = '{5, 4, 3, 2, 2, 1, 1, 0, 0};
  int offs [3] = '{2000, 1000, 3000};
  int failures = 0, cmp_count = 0, cyc = 0, i, j, k, t, n, c, pos;
  bit up, ds, rise;
  // --------------------------------
  // Design and step source
  // --------------------------------
  smi_indexer #(.SLEEP_CYC(20), .ON_CYC(20), .CW(17)) smi_indexer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step(step),
    .step_direction(step_direction), .output_disable_n(output_disable_n),
    .sleep_request_low(sleep_request_low),
    .auto_decay_enable(auto_decay_enable), .step_mode_sel0(m0),
    .step_mode_sel1(m1), .torque_scale_sel0(t0), .torque_scale_sel1(t1),
    .offtime_select(toff), .motor_supply(motor_supply),
    .chop_trip(chop_trip), .fault_ext(fault_ext), .drive(drive),
    .bridge_enable(bridge_enable), .chop_off(chop_off),
    .decay_fast(decay_fast), .sleep_active(sleep_active),
    .fault_indicator_n_o(fo), .fault_indicator_n_oe(foe), .irq(irq));
  smi_step_ctrl smi_step_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .req(req), .dir_req(dir_req), .done(done), .step(step),
    .step_direction(step_direction));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic int next_pos(int p, int s, bit u);
    int sz, b, r;
    sz = 1 << s;
    b = (s == 5) ? 16 : 0;
    r = (p - b + 128) % 128;
    r = u ? (r / sz + 1) * sz : ((r + sz - 1) / sz - 1) * sz;
    return (r + b + 128) % 128;
  endfunction : next_pos
  task automatic check(input logic [31:0] seen, exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int w8;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w8 = 0;
    do begin
      @(posedge pclk);
      w8++;
    end while (pready !== 1'b1 && w8 < 50);
    if (pready !== 1'b1) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_cyc(input int m);
    repeat (m) @(posedge pclk);
  endtask : wait_cyc
  task automatic wait_run;
    int r;
    r = 0;
    do begin
      apb(0, `SMI_STAT_OFS, 32'h0000_0000);
      r++;
    end while (q[13:12] !== 2'd2 && r < 15);
    check(q[13:12], 2'd2, "run state");
  endtask : wait_run
  task automatic step_edge(input bit u);
    int r;
    @(posedge pclk);
    req <= 1'b1;
    dir_req <= u;
    @(posedge pclk);
    req <= 1'b0;
    r = 0;
    do begin
      @(posedge pclk);
      r++;
    end while (done !== 1'b1 && r < 20);
  endtask : step_edge
  task automatic wrap_up;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(24));
    wait_cyc(5);
    presetn <= 1'b1;
    wait_cyc(2);
    check(sleep_active, 1'b1, "locked");
    check(foe, 1'b0, "fault low");
    check(fo, 1'b0, "fault level");
    apb(0, `SMI_STAT_OFS, 32'h0000_0000);
    check(q[6:0], 7'h10, "home");
    apb(0, 8'h10, 32'h0000_0000);
    check(e, 1'b1, "unmapped error");
    check(q, 32'h0000_0000, "unmapped data");
    motor_supply <= 16'h0BB8;
    wait_cyc(5);
    check(foe, 1'b0, "at 3000");
    motor_supply <= 16'h0BB9;
    wait_cyc(3);
    check(foe, 1'b1, "released");
    sleep_request_low <= 1'b1;
    wait_run();
    check(drive, 16'h4747, "home drive");
    pos = 16;
    for (i = 0; i < 40; i++) begin
      k = (i < 9) ? i : $urandom % 9;
      up = $urandom % 2;
      t = $urandom % 9;
      ds = $urandom % 2;
      @(posedge pclk);
      m1 <= pins[k / 3];
      m0 <= pins[k % 3];
      t1 <= pins[t / 3];
      t0 <= pins[t % 3];
      output_disable_n <= ds;
      rise = (step === 1'b0);
      step_edge(up);
      if (rise || k == 4 || k == 6 || k == 8) pos = next_pos(pos, shf[k], up);
      apb(0, `SMI_STAT_OFS, 32'h0000_0000);
      check(q[6:0], pos[6:0], "pos");
      check(q[10:8], shf[k], "res");
      check(bridge_enable, !ds && t != 8, "bridge");
    end
    apb(0, `SMI_INT_OFS, 32'h0000_0000);
    check({q[2], q[0], irq}, 3'h6, "events");
    apb(1, `SMI_MASK_OFS, 32'h0000_0001);
    wait_cyc(1);
    check(irq, 1'b1, "irq on");
    apb(1, `SMI_INT_OFS, 32'h0000_0005);
    apb(0, `SMI_INT_OFS, 32'h0000_0000);
    check({q[0], irq}, 2'h0, "irq cleared");
    output_disable_n <= 1'b0;
    t0 <= 2'b01;
    t1 <= 2'b01;
    for (j = 0; j < 3; j++) begin
      toff <= pins[j];
      @(posedge pclk);
      chop_trip <= 2'b11;
      @(posedge pclk);
      chop_trip <= 2'b00;
      n = 0;
      c = 0;
      while (c < 4000 && !(n > 0 && chop_off[0] === 1'b0)) begin
        @(posedge pclk);
        c++;
        if (chop_off[0] === 1'b1) n++;
      end
      check(n, offs[j], "off time");
    end
    fault_ext <= 1'b1;
    wait_cyc(3);
    check(foe, 1'b0, "ext fault");
    fault_ext <= 1'b0;
    sleep_request_low <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sleep_active !== 1'b1 && n < 40);
    check(sleep_active, 1'b1, "asleep");
    sleep_request_low <= 1'b1;
    wait_run();
    apb(0, `SMI_STAT_OFS, 32'h0000_0000);
    check(q[6:0], 7'h10, "home again");
    auto_decay_enable <= 1'b1;
    m1 <= 2'b10;
    m0 <= 2'b00;
    if (step === 1'b1) step_edge(1);
    step_edge(1);
    wait_cyc(2);
    check(decay_fast, 2'b01, "auto decay");
    auto_decay_enable <= 1'b0;
    apb(1, `SMI_CTRL_OFS, 32'h0000_0001);
    wait_cyc(1);
    check(decay_fast, 2'b11, "fixed decay");
    motor_supply <= 16'h0B86;
    wait_cyc(5);
    check(foe, 1'b1, "hysteresis");
    motor_supply <= 16'h0B53;
    wait_cyc(5);
    check({foe, sleep_active}, 2'b01, "lockout");
    wrap_up();
  end
endmodule : stepper_microstep_indexer_bench
